// *** include/eips_pkg.sv ***
// ==========================================================
// shared constants and types for the edge interrupt pulse shaper
package eips_pkg;
    // register map
    localparam logic [11:0] timing_offset     = 12'h340;  // irq_edge_timing byte address
    // field layout
    localparam int          gap_lsb           = 24;       // minimum gap field low bit
    localparam int          gap_width         = 8;        // minimum gap field width
    localparam int          count_lsb         = 0;        // pulse length field low bit
    localparam int          count_width       = 16;       // pulse length field width
    // reset values
    localparam logic [7:0]  gap_reset         = 8'h00;    // no spacing after reset
    localparam logic [15:0] count_reset       = 16'h000f; // about 600 ns pulse
    // timing
    localparam int          clock_mhz         = 25;       // system clock rate
    localparam int          microframe_us     = 125;      // one microframe
    localparam int          microframe_cycles = microframe_us * clock_mhz;

    // register bus request
    typedef struct packed {
        logic [11:0] addr;   // byte address
        logic [31:0] wdata;  // write data
        logic        wr;     // write strobe
        logic        rd;     // read strobe
    } eips_bus_t;

    // shaper states
    typedef enum logic [1:0] {
        eips_idle  = 2'b00,  // waiting for an event
        eips_pulse = 2'b01,  // pin asserted
        eips_gap   = 2'b10   // enforcing spacing
    } eips_state_t;
endpackage

// *** rtl/eips_shaper.sv ***
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module eips_shaper #(
    parameter int frame_cycles = eips_pkg::microframe_cycles  // clocks per microframe
) (
    input  wire logic             clock,      // system clock
    input  wire logic             nrst,       // synchronous reset, active low
    input  wire eips_pkg::eips_bus_t bus,     // register bus request
    output logic [31:0]           rdata,      // read data, cycle after read strobe
    input  wire logic             event_in,   // interrupt event, one cycle
    input  wire logic             level_mode, // 1: level signalling
    output logic                  irq         // interrupt pin, active high
);
    import eips_pkg::*;

    // ==========================================================
    // parameter guard
    // the microframe counter is 16 bits wide and must count at least one clock
    // per microframe, so anything outside that span is refused at elaboration
    if (frame_cycles < 1 || frame_cycles > 65535) begin : bad_frame_cycles
        $error("frame_cycles out of range");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]  gap;       // minimum gap in microframes
        logic [15:0] count;     // pulse length in clocks
        logic [31:0] rdata;     // read data register
        eips_state_t state;     // shaper state
        logic [15:0] clk_cnt;   // pulse clock counter
        logic [15:0] frm_cnt;   // clocks within microframe
        logic [7:0]  gap_cnt;   // microframes left
        logic        pending;   // held event
        logic        irq;       // pin
    } eips_regs_t;

    eips_regs_t r;        // current state
    eips_regs_t next_r;   // next state

    // ==========================================================
    // next state logic
    // one pass decides bus reads, bus writes and the pin sequencer;
    // a write and an event in the same cycle both take effect, and a
    // new pulse length also applies to a pulse already running
    always_comb begin
        logic ev;  // something wants a pulse this cycle
        ev = event_in | r.pending;
        next_r = r;
        next_r.rdata = 32'h0000_0000;
        // register read
        if (bus.rd && bus.addr == timing_offset) begin
            next_r.rdata[gap_lsb +: gap_width]     = r.gap;
            next_r.rdata[count_lsb +: count_width] = r.count;
        end
        // register write; reserved bits dropped
        if (bus.wr && bus.addr == timing_offset) begin
            next_r.gap   = bus.wdata[gap_lsb +: gap_width];
            next_r.count = bus.wdata[count_lsb +: count_width];
        end
        if (level_mode) begin
            // level mode: follow the event, no gap
            next_r.irq     = event_in;
            next_r.state   = eips_idle;
            next_r.pending = 1'b0;
        end else begin
            case (r.state)
                eips_idle: begin
                    // start a pulse as soon as something is waiting and the pulse length is not zero
                    if (ev && r.count != 16'h0000) begin
                        next_r.irq     = 1'b1;
                        next_r.clk_cnt = 16'h0001;
                        next_r.pending = 1'b0;
                        next_r.state   = eips_pulse;
                    end else begin
                        next_r.pending = 1'b0;
                        next_r.irq     = 1'b0;
                    end
                end
                eips_pulse: begin
                    // hold the pin for the programmed clocks
                    if (event_in) begin
                        next_r.pending = 1'b1;
                    end
                    if (r.clk_cnt >= r.count) begin
                        next_r.irq     = 1'b0;
                        next_r.frm_cnt = 16'h0000;
                        next_r.gap_cnt = r.gap;
                        next_r.state   = (r.gap == 8'h00) ? eips_idle : eips_gap;
                    end else begin
                        next_r.clk_cnt = r.clk_cnt + 16'h0001;
                    end
                end
                eips_gap: begin
                    // count microframes before the next pulse
                    // frm_cnt runs 0 .. frame_cycles-1 once per microframe,
                    // gap_cnt holds the microframes still to wait
                    if (event_in) begin
                        next_r.pending = 1'b1;
                    end
                    if (r.frm_cnt == 16'(frame_cycles - 1)) begin
                        next_r.frm_cnt = 16'h0000;
                        next_r.gap_cnt = r.gap_cnt - 8'h01;
                        if (r.gap_cnt <= 8'h01) begin
                            next_r.state = eips_idle;
                        end
                    end else begin
                        next_r.frm_cnt = r.frm_cnt + 16'h0001;
                    end
                end
                default: begin
                    next_r.state = eips_idle;
                end
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            r       <= '0;
            r.gap   <= gap_reset;
            r.count <= count_reset;
            r.state <= eips_idle;
        end else begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign irq   = r.irq;

    // ==========================================================
    // checks
    reset_count_a: assert property (@(posedge clock) $rose(nrst) |-> r.count == count_reset)
        else $error("pulse length not at reset value");
    pulse_len_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_pulse && r.clk_cnt >= r.count && !level_mode) |=> !irq)
        else $error("pulse did not end at count");
    gap_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_gap && !level_mode) |=> !irq)
        else $error("pulse inside minimum gap");
    level_follow_a: assert property (@(posedge clock) disable iff (!nrst)
        level_mode |=> irq == $past(event_in))
        else $error("level output wrong");
    zero_gap_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_idle && event_in && !level_mode && r.count != 16'h0000) |=> irq)
        else $error("event not pulsed at once");
    pending_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_gap && event_in && !level_mode) |=> r.pending)
        else $error("event lost during gap");
    reg_write_a: assert property (@(posedge clock) disable iff (!nrst)
        (bus.wr && bus.addr == timing_offset) |=> r.count == $past(bus.wdata[15:0]))
        else $error("write not stored");
    read_data_a: assert property (@(posedge clock) disable iff (!nrst)
        (bus.rd && bus.addr == timing_offset) |=> rdata[23:16] == 8'h00)
        else $error("reserved bits not zero");

    // ==========================================================
    // further checks on the sequencer and the register port
    // pulse state always has the pin raised: the pin is set on entry
    // and only lowered on the way out
    pulse_high_a: assert property (@(posedge clock) disable iff (!nrst)
        r.state == eips_pulse |-> irq)
        else $error("pin low during pulse");
    // in steady edge mode the idle state never leaves the pin high
    idle_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_idle && !level_mode && !$past(level_mode)) |-> !irq)
        else $error("pin high while idle");
    // the gap state is only entered with microframes left to wait
    gap_left_a: assert property (@(posedge clock) disable iff (!nrst)
        r.state == eips_gap |-> r.gap_cnt != 8'h00)
        else $error("gap state with nothing to wait");
    // a zero gap sends the sequencer straight back to idle
    zero_gap_idle_a: assert property (@(posedge clock) disable iff (!nrst)
        (r.state == eips_pulse && r.clk_cnt >= r.count && r.gap == 8'h00
         && !level_mode) |=> r.state == eips_idle)
        else $error("zero gap still waited");
    // level mode parks the sequencer and forgets held events
    level_idle_a: assert property (@(posedge clock) disable iff (!nrst)
        level_mode |=> (r.state == eips_idle && !r.pending))
        else $error("sequencer busy in level mode");
    // reset leaves the pin low, the read port quiet and the default length
    reset_state_a: assert property (@(posedge clock)
        !nrst |=> (!irq && rdata == 32'h0000_0000 && r.count == count_reset))
        else $error("reset state wrong");
    // a read of the timing word returns the stored pulse length
    read_back_a: assert property (@(posedge clock) disable iff (!nrst)
        (bus.rd && bus.addr == timing_offset) |=> rdata[15:0] == $past(r.count))
        else $error("pulse length not read back");
    // reads of any other address return zero
    unmapped_read_a: assert property (@(posedge clock) disable iff (!nrst)
        (bus.rd && bus.addr != timing_offset) |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // the gap field written is the gap field stored
    gap_write_a: assert property (@(posedge clock) disable iff (!nrst)
        (bus.wr && bus.addr == timing_offset) |=> r.gap == $past(bus.wdata[31:24]))
        else $error("gap not stored");
    // the read strobe leaves the data for one cycle only
    read_once_a: assert property (@(posedge clock) disable iff (!nrst)
        !bus.rd |=> rdata == 32'h0000_0000)
        else $error("read data held too long");
endmodule

// *** test/eips_irq_sink.sv ***
`timescale 1ns/1ps
// ==========================================================
// host interrupt input: measures each pulse and each low stretch
module eips_irq_sink (
    input  wire logic        clock,  // system clock
    input  wire logic        nrst,   // synchronous reset, active low
    input  wire logic        irq,    // interrupt pin from the shaper
    output logic [15:0]      width,  // high cycles of the last pulse
    output logic [15:0]      low,    // low cycles before the last pulse
    output logic [7:0]       pulses  // rising edges seen
);
    logic [15:0] run;   // samples at the current level
    logic        prev;  // previous sample of the pin
    // edge-sensitive input: a change closes the current stretch
    always_ff @(posedge clock) begin
        if (!nrst) begin
            {run, prev, width, low, pulses} <= '0;
        end else begin
            prev <= irq;
            run  <= (irq != prev) ? 16'h0001 : run + 16'h0001;
            if (irq && !prev) begin  // rising edge
                low    <= run;
                pulses <= pulses + 8'h01;
            end
            if (!irq && prev) width <= run;  // falling edge
        end
    end
endmodule

// *** test/edge_irq_pulse_shaper_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
// ==========================================================
// self-checking bench for the pulse shaper
module edge_irq_pulse_shaper_tb;
    import eips_pkg::*;
    localparam int fc = 4;  // short microframe for simulation
    logic        clock = 1'b0, nrst = 1'b0, event_in = 1'b0, level_mode = 1'b0, irq;
    eips_bus_t   bus = '0;  // register bus request
    logic [31:0] rdata;     // register read data
    logic [15:0] width, low, cnt;
    logic [7:0]  pulses;
    int          fails = 0, check_count = 0;
    always #20 clock = ~clock;  // 25 MHz
    eips_shaper #(.frame_cycles(fc)) DUT (.clock(clock), .nrst(nrst), .bus(bus),
        .rdata(rdata), .event_in(event_in), .level_mode(level_mode), .irq(irq));
    eips_irq_sink sink (.clock(clock), .nrst(nrst), .irq(irq), .width(width),
        .low(low), .pulses(pulses));
    // ==========================================================
    // bus cycles and stimulus
    task automatic wr(input logic [31:0] d);
        @(posedge clock) bus <= '{timing_offset, d, 1'b1, 1'b0};
        @(posedge clock) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock) bus.rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    function automatic logic [31:0] exp_word(input logic [7:0] g, input logic [15:0] c);
        return {g, 8'h00, c};  // reserved bits read as zero
    endfunction
    task automatic fire();  // one-cycle event
        @(posedge clock) event_in <= 1'b1;
        @(posedge clock) event_in <= 1'b0;
    endtask
    task automatic wait_n(input logic [7:0] n);  // bounded wait for n pulses
        int i;
        i = 0;
        while (!(pulses === n && irq === 1'b0) && i < 500) begin
            @(posedge clock);
            i++;
        end
        if (i == 500) begin
            fails++;
            end_sim();
        end
        repeat (2) @(posedge clock);
    endtask
    task automatic end_sim();
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'had77c0a3));
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd(timing_offset, 32'h0000000f);
        rd(12'h344, 32'h0);
        for (int k = 0; k < 4; k++) begin  // pulse length 1, then random pulse lengths
            cnt = (k == 0) ? 16'h0001 : 16'($urandom_range(2, 40));
            wr({8'h00, 8'h00, cnt});
            rd(timing_offset, exp_word(8'h00, cnt));
            fire();
            wait_n(8'(k + 1));
            `CHK(width, cnt)
        end
        wr({8'h02, 8'h00, 16'h0003});  // gap of two microframes
        rd(timing_offset, exp_word(8'h02, 16'h0003));
        fire();
        fire();
        wait_n(8'd6);
        `CHK(low >= 16'(2 * fc), 1'b1)
        `CHK(pulses, 8'd6)
        repeat (12) @(posedge clock);
        wr({8'h00, 8'h00, 16'h0003});
        fire();
        fire();
        wait_n(8'd8);
        `CHK(low, 16'h0001)
        wr({8'h05, 8'h00, 16'h0003});
        @(posedge clock) level_mode <= 1'b1;
        for (int k = 0; k < 3; k++) begin  // level follows event despite gap
            @(posedge clock) event_in <= 1'b1;
            repeat (2) @(posedge clock);
            #1 `CHK(irq, 1'b1)
            @(posedge clock) event_in <= 1'b0;
            repeat (2) @(posedge clock);
            #1 `CHK(irq, 1'b0)
        end
        end_sim();
    end
endmodule
